// ---- logic/scanner_process_image_io.sv ----
// cyclic process-data image framer of the code reader
`timescale 1ns/100ps
`default_nettype none
module scanner_process_image_io (
    input wire logic core_clk, // system clock, 25 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic cycle_tick, // one pulse per fieldbus exchange
    input wire scanner_image_pkg::out_image_t out_image, // controller output image
    output scanner_image_pkg::in_image_t in_image, // input image to controller
    input wire logic [7:0] cfg_len, // configuration image length
    input wire logic cfg_ack_mode, // acknowledge mode from configuration
    input wire logic sw1_ext_mode, // output 1 set to external event
    input wire logic sw2_ext_mode, // output 2 set to external event
    input wire logic hdr_valid, // decoder starts a result
    input wire scanner_image_pkg::result_hdr_t hdr, // result header
    input wire logic byte_valid, // decoder offers a result byte
    output logic byte_ready, // fifo accepts the byte
    input wire logic [7:0] byte_data, // result byte
    input wire logic decode_good, // valid result decoded pulse
    input wire logic failed_decode_event, // activation ended without read
    input wire logic fault_event, // reader error pulse
    input wire logic warn_event, // reader warning pulse
    output logic sw1_out, // switching output 1
    output logic sw2_out, // switching output 2
    output logic standby_out, // standby commanded
    output logic [15:0] event_count1, // switch 1 events
    output logic [15:0] event_count2 // switch 2 events
);
    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    scanner_image_pkg::framer_state_t q;
    scanner_image_pkg::framer_state_t d;
    logic ack_mode;
    logic ack_chg;
    logic rst_rise;
    logic errack_chg;
    logic cnt1_clr;
    logic cnt2_clr;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    logic pop_ok;

    // saturate a 16-bit count into an image byte
    function automatic logic [7:0] sat8(input logic [15:0] v);
        sat8 = (v > 16'h00ff) ? 8'hff : v[7:0];
    endfunction

    // next fragment or end of result
    function automatic scanner_image_pkg::framer_state_t advance(
        input scanner_image_pkg::framer_state_t s
    );
        advance = s;
        if (16'(s.idx + 1'b1) < s.total) begin
            advance.idx = 16'(s.idx + 1'b1);
            advance.fill = '0;
            advance.st = scanner_image_pkg::ST_FILL;
        end else begin
            advance.st = scanner_image_pkg::ST_IDLE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // result byte buffer

    result_fifo #(
        .WIDTH(scanner_image_pkg::BYTE_W),
        .DEPTH(scanner_image_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .flush(rst_rise),
        .in_valid(byte_valid),
        .in_ready(byte_ready),
        .in_data(byte_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // command decode, taken once per fieldbus exchange

    // configuration of length zero keeps the defaults, acknowledge mode off
    assign ack_mode = (cfg_len != scanner_image_pkg::CFG_LEN_NONE) && cfg_ack_mode;
    assign ack_chg = cycle_tick
        && (out_image.cmd[scanner_image_pkg::CMD_ACK_BIT] != q.cmd[scanner_image_pkg::CMD_ACK_BIT]);
    assign rst_rise = cycle_tick && out_image.cmd[scanner_image_pkg::CMD_RST_BIT]
        && !q.cmd[scanner_image_pkg::CMD_RST_BIT];
    // either direction of the acknowledge bit counts
    assign errack_chg = cycle_tick && (out_image.cmd[scanner_image_pkg::CMD_ERRACK_BIT]
        != q.cmd[scanner_image_pkg::CMD_ERRACK_BIT]);
    assign cnt1_clr = cycle_tick && out_image.sw[scanner_image_pkg::CNT1_RST_BIT]
        && !q.swcmd[scanner_image_pkg::CNT1_RST_BIT];
    assign cnt2_clr = cycle_tick && out_image.sw[scanner_image_pkg::CNT2_RST_BIT]
        && !q.swcmd[scanner_image_pkg::CNT2_RST_BIT];

    // pull bytes only while a fragment is being filled
    assign pop_ok = (q.st == scanner_image_pkg::ST_FILL) && (q.left != '0)
        && (q.fill != 4'(scanner_image_pkg::DATA_BYTES));
    assign fifo_pop = pop_ok && fifo_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        if (cycle_tick) begin
            d.cmd = out_image.cmd;
            d.swcmd = out_image.sw;
        end

        // fault and warning flags, a new event wins over the clear
        d.fault = fault_event || (q.fault && !errack_chg);
        d.warn = warn_event || (q.warn && !errack_chg);

        // result indication for switching output 2
        if (decode_good) begin
            d.sw2_res = 1'b1;
        end else if (failed_decode_event) begin
            d.sw2_res = 1'b0;
        end
        // direct bits act only with the external-event function
        d.sw_out[0] = sw1_ext_mode ? q.swcmd[scanner_image_pkg::SW1_BIT]
            : q.cmd[scanner_image_pkg::CMD_ACT_BIT];
        d.sw_out[1] = sw2_ext_mode ? q.swcmd[scanner_image_pkg::SW2_BIT] : q.sw2_res;

        // framing sequence
        unique case (q.st)
            scanner_image_pkg::ST_IDLE: begin
                if (q.pend) begin
                    d.len = q.pend_len;
                    d.user = q.pend_user;
                    d.rem = q.pend_len;
                    d.pend = 1'b0;
                    d.total = '0;
                    d.res_count = 8'(q.res_count + 1'b1);
                    d.st = scanner_image_pkg::ST_COUNT;
                end else if (hdr_valid) begin
                    d.len = hdr.len;
                    d.user = hdr.user;
                    d.rem = hdr.len;
                    d.total = '0;
                    d.res_count = 8'(q.res_count + 1'b1);
                    d.st = scanner_image_pkg::ST_COUNT;
                end
            end
            scanner_image_pkg::ST_COUNT: begin
                // one fragment per ten bytes, at least one
                d.total = 16'(q.total + 1'b1);
                if (q.rem > 16'(scanner_image_pkg::DATA_BYTES)) begin
                    d.rem = 16'(q.rem - 16'(scanner_image_pkg::DATA_BYTES));
                end else begin
                    d.idx = '0;
                    d.left = q.len;
                    d.fill = '0;
                    d.st = scanner_image_pkg::ST_FILL;
                end
            end
            scanner_image_pkg::ST_FILL: begin
                if (!pop_ok) begin
                    d.frag_len = 8'(q.fill);
                    if (q.idx == '0) begin
                        d.newtog = !q.newtog;
                    end
                    d.st = scanner_image_pkg::ST_PRESENT;
                end else if (fifo_valid) begin
                    d.buf_data[q.fill] = fifo_data;
                    d.fill = 4'(q.fill + 1'b1);
                    d.left = 16'(q.left - 1'b1);
                end
            end
            scanner_image_pkg::ST_PRESENT: begin
                // fragment is published at this tick
                if (cycle_tick) begin
                    if (ack_mode) begin
                        d.st = scanner_image_pkg::ST_WAIT_ACK;
                    end else begin
                        d = advance(d);
                    end
                end
            end
            scanner_image_pkg::ST_WAIT_ACK: begin
                if (ack_chg) begin
                    d.acc_tog = !q.acc_tog;
                    d.err_code = scanner_image_pkg::ERR_NONE;
                    d = advance(d);
                end
            end
            default: begin
                d.st = scanner_image_pkg::ST_IDLE;
            end
        endcase

        // acknowledge with nothing awaiting it is rejected
        if (ack_chg && (q.st != scanner_image_pkg::ST_WAIT_ACK)) begin
            d.rej_tog = !q.rej_tog;
            d.err_code = scanner_image_pkg::ERR_NOT_WAITING;
        end

        // data reset drops everything held and is accepted
        if (rst_rise) begin
            d.st = scanner_image_pkg::ST_IDLE;
            d.pend = 1'b0;
            d.ovfl = 1'b0;
            d.acc_tog = !q.acc_tog;
            d.err_code = scanner_image_pkg::ERR_NONE;
        end

        // a header not taken above waits in the single spare slot
        if (hdr_valid && !((q.st == scanner_image_pkg::ST_IDLE) && !q.pend)) begin
            if (d.pend) begin
                d.ovfl = 1'b1;
            end else begin
                d.pend = 1'b1;
                d.pend_len = hdr.len;
                d.pend_user = hdr.user;
            end
        end

        // publish the input image once per exchange
        if (cycle_tick) begin
            if (q.fault) begin
                d.image.reader_state = scanner_image_pkg::STAT_ERROR;
            end else if (q.warn) begin
                d.image.reader_state = scanner_image_pkg::STAT_WARNING;
            end else if (q.cmd[scanner_image_pkg::CMD_STBY_BIT]) begin
                d.image.reader_state = scanner_image_pkg::STAT_STANDBY;
            end else begin
                d.image.reader_state = scanner_image_pkg::STAT_READY;
            end
            d.image.io_state = '0;
            d.image.io_state[scanner_image_pkg::IO1_BIT] = q.sw_out[0];
            d.image.io_state[scanner_image_pkg::IO2_BIT] = q.sw_out[1];
            d.image.handshake = '0;
            d.image.handshake[scanner_image_pkg::ERR_LSB +: 3] = q.err_code;
            d.image.handshake[scanner_image_pkg::REJ_BIT] = q.rej_tog;
            d.image.handshake[scanner_image_pkg::ACC_BIT] = q.acc_tog;
            if (q.st == scanner_image_pkg::ST_PRESENT || q.st == scanner_image_pkg::ST_WAIT_ACK) begin
                d.image.frag_index = sat8(q.idx);
                d.image.frags_left = sat8(16'(q.total - q.idx - 1'b1));
                d.image.frag_len = q.frag_len;
                d.image.data = q.buf_data;
                d.image.len_low = q.len[7:0];
                d.image.len_high = q.len[15:8];
            end
            d.image.res_count = q.res_count;
            d.image.flags = '0;
            d.image.flags[scanner_image_pkg::FLAG_WAIT_BIT] =
                q.st == scanner_image_pkg::ST_WAIT_ACK;
            d.image.flags[scanner_image_pkg::FLAG_NEWRES_BIT] = q.newtog;
            d.image.flags[scanner_image_pkg::FLAG_OVFL_BIT] = q.ovfl;
            d.image.flags[scanner_image_pkg::FLAG_FURTHER_BIT] = q.pend;
            d.image.flags[scanner_image_pkg::FLAG_USER_BIT] = q.user;
            d.image.flags[scanner_image_pkg::FLAG_ACT_BIT] =
                q.cmd[scanner_image_pkg::CMD_ACT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= scanner_image_pkg::STATE_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs and switch event counters

    assign in_image = q.image;
    assign sw1_out = q.sw_out[0];
    assign sw2_out = q.sw_out[1];
    assign standby_out = q.cmd[scanner_image_pkg::CMD_STBY_BIT];

    switch_event_counter u_cnt1 (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .level(q.sw_out[0]),
        .clear(cnt1_clr),
        .count(event_count1)
    );

    switch_event_counter u_cnt2 (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .level(q.sw_out[1]),
        .clear(cnt2_clr),
        .count(event_count2)
    );
endmodule
`default_nettype wire

// ---- pkg/scanner_image_pkg.sv ----
// shared constants and types of the process-data image framer
package scanner_image_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int DATA_BYTES = 10;
    localparam int FIFO_DEPTH = 4;
    localparam int BYTE_W = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // input image byte offsets
    localparam int IN_STATE_OFS = 0;
    localparam int IN_IO_OFS = 1;
    localparam int IN_HANDSHAKE_OFS = 2;
    localparam int IN_FRAG_INDEX_OFS = 3;
    localparam int IN_FRAGS_LEFT_OFS = 4;
    localparam int IN_FRAG_LEN_OFS = 5;
    localparam int IN_RES_COUNT_OFS = 6;
    localparam int IN_FLAGS_OFS = 7;
    localparam int IN_LEN_LOW_OFS = 8;
    localparam int IN_LEN_HIGH_OFS = 9;
    localparam int IN_DATA_OFS = 10;

    // output image byte offsets
    localparam int OUT_CMD_OFS = 0;
    localparam int OUT_SW_OFS = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // output command byte 0 fields
    localparam int CMD_ACT_BIT = 0;
    localparam int CMD_ACK_BIT = 1;
    localparam int CMD_RST_BIT = 2;
    localparam int CMD_ERRACK_BIT = 3;
    localparam int CMD_STBY_BIT = 4;
    // output switch command byte 1 fields
    localparam int SW1_BIT = 0;
    localparam int CNT1_RST_BIT = 1;
    localparam int SW2_BIT = 2;
    localparam int CNT2_RST_BIT = 3;

    // input image field positions
    localparam int IO1_BIT = 0;
    localparam int IO2_BIT = 4;
    localparam int ACC_BIT = 0;
    localparam int REJ_BIT = 1;
    localparam int ERR_LSB = 4;
    localparam int FLAG_ACT_BIT = 0;
    localparam int FLAG_USER_BIT = 1;
    localparam int FLAG_FURTHER_BIT = 2;
    localparam int FLAG_OVFL_BIT = 3;
    localparam int FLAG_NEWRES_BIT = 4;
    localparam int FLAG_WAIT_BIT = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // device status codes and error codes
    localparam logic [7:0] STAT_STANDBY = 8'h0a;
    localparam logic [7:0] STAT_READY = 8'h0f;
    localparam logic [7:0] STAT_ERROR = 8'h80;
    localparam logic [7:0] STAT_WARNING = 8'h81;
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_NOT_WAITING = 3'h1;
    localparam logic [7:0] CFG_LEN_NONE = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef logic [7:0] byte_t;

    typedef struct packed {
        byte_t cmd; // output command byte
        byte_t sw;  // output switch command byte
    } out_image_t;

    typedef struct packed {
        logic [15:0] len; // result length in bytes
        logic user;       // result is user data or a command
    } result_hdr_t;

    typedef struct packed {
        byte_t reader_state;
        byte_t io_state;
        byte_t handshake;
        byte_t frag_index;
        byte_t frags_left;
        byte_t frag_len;
        byte_t res_count;
        byte_t flags;
        byte_t len_low;
        byte_t len_high;
        logic [DATA_BYTES-1:0][7:0] data;
    } in_image_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_COUNT = 3'b001,
        ST_FILL = 3'b010,
        ST_PRESENT = 3'b011,
        ST_WAIT_ACK = 3'b100
    } frame_state_t;

    typedef struct packed {
        frame_state_t st;
        byte_t cmd;
        byte_t swcmd;
        logic [15:0] len;
        logic user;
        logic [15:0] rem;
        logic [15:0] total;
        logic [15:0] idx;
        logic [15:0] left;
        logic [3:0] fill;
        logic [DATA_BYTES-1:0][7:0] buf_data;
        byte_t frag_len;
        logic pend;
        logic [15:0] pend_len;
        logic pend_user;
        logic ovfl;
        logic newtog;
        logic acc_tog;
        logic rej_tog;
        logic [2:0] err_code;
        byte_t res_count;
        logic fault;
        logic warn;
        logic sw2_res;
        logic [1:0] sw_out;
        in_image_t image;
    } framer_state_t;

    typedef struct packed {
        logic prev;
        logic [15:0] count;
    } counter_state_t;

    localparam in_image_t IMAGE_RESET = '{reader_state: STAT_READY, default: '0};
    localparam framer_state_t STATE_RESET = '{st: ST_IDLE, image: IMAGE_RESET, default: '0};
    localparam counter_state_t COUNTER_RESET = '{prev: 1'b0, count: COUNT_RESET};

endpackage

// ---- logic/result_fifo.sv ----
// small flip-flop fifo between the decoder byte stream and the framer
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic core_clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic flush, // drop all stored words
    input wire logic in_valid, // source offers a word
    output logic in_ready, // fifo has room
    input wire logic [WIDTH-1:0] in_data, // word from source
    output logic out_valid, // a word is stored
    input wire logic out_ready, // sink takes the word
    output logic [WIDTH-1:0] out_data // oldest word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t d;
    logic push;
    logic pop;

    // handshakes straight from the occupancy count
    assign in_ready = q.cnt != (AW + 1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data = q.mem[q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr = AW'(q.wr + 1'b1);
        end
        if (pop) begin
            d.rd = AW'(q.rd + 1'b1);
        end
        d.cnt = (AW + 1)'(q.cnt + push - pop);
        if (flush) begin
            d.wr = '0;
            d.rd = '0;
            d.cnt = '0;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// ---- logic/switch_event_counter.sv ----
// counts rising edges of one switching output
`timescale 1ns/100ps
`default_nettype none
module switch_event_counter (
    input wire logic core_clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic level, // switching output level
    input wire logic clear, // one-cycle clear request
    output logic [15:0] count // rising edges seen
);
    scanner_image_pkg::counter_state_t q;
    scanner_image_pkg::counter_state_t d;

    assign count = q.count;

    // an edge in the clear cycle still counts as one
    always_comb begin
        d = q;
        d.prev = level;
        if (clear) begin
            d.count = scanner_image_pkg::COUNT_RESET;
        end
        if (level && !q.prev) begin
            d.count = 16'(d.count + 1'b1);
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= scanner_image_pkg::COUNTER_RESET;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// ---- test/scanner_process_image_io_sva.sv ----
// port assertions of the image framer
`timescale 1ns/100ps
`default_nettype none
module image_io_checker (
    input wire logic core_clk, // clock
    input wire logic arst_n, // reset
    input wire logic cycle_tick, // exchange
    input wire scanner_image_pkg::out_image_t out_image, // commands
    input wire scanner_image_pkg::in_image_t in_image, // image
    input wire logic [7:0] cfg_len, // config size
    input wire logic sw1_ext_mode, // out 1 external
    input wire logic sw2_ext_mode, // out 2 external
    input wire logic decode_good, // good read
    input wire logic failed_decode_event, // failed read
    input wire logic sw1_out, // output 1
    input wire logic sw2_out // output 2
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // image fields and switching outputs tied to their causes
    status_code_a: assert property (in_image.reader_state inside {8'h0a, 8'h0f, 8'h80, 8'h81})
        else $error("status code out of set");
    sw1_follow_a: assert property (cycle_tick && !sw1_ext_mode |->
        ##2 sw1_out == $past(out_image.cmd[0], 2)) else $error("output 1 off activation");
    sw2_good_a: assert property (decode_good && !sw2_ext_mode |-> ##[1:3] sw2_out)
        else $error("output 2 not set on good read");
    sw2_fail_a: assert property (failed_decode_event && !sw2_ext_mode |-> ##[1:3] !sw2_out)
        else $error("output 2 not cleared on failed read");
    io2_mirror_a: assert property (cycle_tick |=> in_image.io_state[4] == $past(sw2_out))
        else $error("io bit 2 not mirroring output 2");
    image_hold_a: assert property (!cycle_tick |=> $stable(in_image))
        else $error("image changed between exchanges");
    hs_reserved_a: assert property (in_image.handshake[7] == 1'b0 && in_image.handshake[3:2] == 2'h0)
        else $error("handshake reserved bits set");
    flags_reserved_a: assert property (in_image.flags[7:6] == 2'h0)
        else $error("flag reserved bits set");
    no_ack_wait_a: assert property (cfg_len == 8'h00 |-> !in_image.flags[5])
        else $error("waiting for acknowledge without configuration");
    frag_size_a: assert property (in_image.frag_len <= 8'h0a)
        else $error("fragment size above data bytes");
endmodule
bind scanner_process_image_io image_io_checker u_chk (.core_clk, .arst_n, .cycle_tick, .out_image,
    .in_image, .cfg_len, .sw1_ext_mode, .sw2_ext_mode, .decode_good, .failed_decode_event,
    .sw1_out, .sw2_out);
`default_nettype wire

// ---- test/plc_image_model.sv ----
// controller model that paces exchanges and sends the output image
`timescale 1ns/100ps
`default_nettype none
module plc_image_model (
    input wire logic core_clk, // clock
    input wire logic arst_n, // reset
    input wire logic [7:0] cmd_req, // command byte, bit 7 clears counters
    input wire logic [3:0] gap, // cycles between exchanges
    output logic cycle_tick, // exchange pulse
    output scanner_image_pkg::out_image_t out_image // image sent
);
    logic [3:0] cnt_q;
    // exchange pacing, image only changes with a tick, off the falling edge
    always @(negedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 4'h3;
            cycle_tick <= 1'b0;
            out_image <= '0;
        end else begin
            cycle_tick <= (cnt_q == 4'h0);
            cnt_q <= (cnt_q == 4'h0) ? gap : cnt_q - 4'h1;
            if (cnt_q == 4'h0) begin
                out_image.cmd <= cmd_req & 8'h1f;
                out_image.sw <= {4'h0, cmd_req[7], 1'b0, cmd_req[7], 1'b0};
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/scanner_process_image_io_tb.sv ----
// self-checking bench of the image framer
`timescale 1ns/100ps
`default_nettype none
module scanner_process_image_io_tb;
    logic core_clk = 1'b0, arst_n = 1'b0, cycle_tick, cfg_ack_mode = 1'b0, hdr_valid = 1'b0;
    logic byte_valid = 1'b0, byte_ready, decode_good = 1'b0, failed_decode_event = 1'b0;
    logic fault_event = 1'b0, warn_event = 1'b0, sw1_out, sw2_out, standby_out;
    logic [7:0] cmd_req = 8'h00, byte_data = 8'h00;
    logic [3:0] gap = 4'h5;
    scanner_image_pkg::result_hdr_t hdr = '0;
    scanner_image_pkg::out_image_t out_image;
    scanner_image_pkg::in_image_t in_image;
    logic [15:0] cnt1, cnt2;
    int errors = 0, compares = 0;
    always #20 core_clk = ~core_clk;
    // controller model and device under test
    plc_image_model u_plc (.core_clk, .arst_n, .cmd_req, .gap, .cycle_tick, .out_image);
    scanner_process_image_io u_dut (.core_clk, .arst_n, .cycle_tick, .out_image, .in_image,
        .cfg_len(8'h00), .cfg_ack_mode, .sw1_ext_mode(1'b0), .sw2_ext_mode(1'b0), .hdr_valid,
        .hdr, .byte_valid, .byte_ready, .byte_data, .decode_good, .failed_decode_event,
        .fault_event, .warn_event, .sw1_out, .sw2_out, .standby_out, .event_count1(cnt1),
        .event_count2(cnt2));
    // comparison, pacing and expectation helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk iff cycle_tick);
        @(negedge core_clk);
    endtask
    task automatic command(input logic [7:0] c);
        cmd_req = c;
        ticks(3);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
        ticks(2);
    endtask
    function automatic int nfrag(input int len);
        return (len == 0) ? 1 : (len + 9) / 10;
    endfunction
    function automatic int fsize(input int len, input int k);
        return (k < nfrag(len) - 1) ? 10 : len - 10 * k;
    endfunction
    // one result streamed in while its fragments are checked
    task automatic result_test(input int len, input logic user);
        logic [7:0] mem [0:39];
        logic nt;
        foreach (mem[i]) mem[i] = 8'($urandom);
        nt = in_image.flags[4];
        gap = 4'(3 + $urandom % 13);
        fork
            begin
                hdr = '{len: 16'(len), user: user};
                hdr_valid = 1'b1;
                @(negedge core_clk);
                hdr_valid = 1'b0;
                for (int i = 0; i < len; i++) begin
                    byte_valid = 1'b1;
                    byte_data = mem[i];
                    @(posedge core_clk iff byte_ready);
                    @(negedge core_clk);
                end
                byte_valid = 1'b0;
            end
            for (int k = 0; k < nfrag(len); k++) begin
                for (int w = 0; w < 9 && (k > 0 ? in_image.frag_index !== 8'(k)
                    : in_image.flags[4] === nt); w++) ticks(1);
                check(in_image.frag_index, 16'(k));
                check(in_image.frags_left, 16'(nfrag(len) - 1 - k));
                check(in_image.frag_len, 16'(fsize(len, k)));
                check(in_image.flags[1], user);
                for (int i = 0; i < fsize(len, k); i++) check(in_image.data[i], mem[10 * k + i]);
                ticks(1);
            end
        join
    endtask
    task automatic complete_run;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #(40 * 30000);
        errors++;
        complete_run();
    end
    // main sequence
    initial begin
        void'($urandom(86871));
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        check(in_image.reader_state, 8'h0f);
        $display("reset test done");
        command(8'h01);
        check(sw1_out, 1'b1);
        check(in_image.flags[0], 1'b1);
        command(8'h00);
        check(sw1_out, 1'b0);
        $display("activation test done");
        for (int i = 0; i < 7; i++) result_test(i == 0 ? 0 : i == 1 ? 10 : i == 2 ? 11
            : int'($urandom % 41), i[0]);
        $display("result test done");
        pulse(decode_good);
        check(in_image.io_state[4], 1'b1);
        pulse(failed_decode_event);
        check(in_image.io_state[4], 1'b0);
        check({cnt1[7:0], cnt2[7:0]}, 16'h0101);
        command(8'h80);
        check({cnt1[7:0], cnt2[7:0]}, 16'h0000);
        $display("output 2 test done");
        pulse(fault_event);
        check(in_image.reader_state, 8'h80);
        command(8'h08);
        check(in_image.reader_state, 8'h0f);
        pulse(warn_event);
        check(in_image.reader_state, 8'h81);
        command(8'h00);
        check(in_image.reader_state, 8'h0f);
        command(8'h10);
        check(in_image.reader_state, 8'h0a);
        check(standby_out, 1'b1);
        command(8'h00);
        $display("status test done");
        cfg_ack_mode = 1'b1;
        command(8'h02);
        check(in_image.handshake, 8'h12);
        command(8'h00);
        check(in_image.handshake, 8'h10);
        command(8'h04);
        check(in_image.handshake, 8'h01);
        $display("handshake test done");
        complete_run();
    end
endmodule
`default_nettype wire
